// file: smcic_asserts.sv
`timescale 1ns/1ps

module smcic_asserts
  import smcic_pkg::*;
#(
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
  parameter int STEP_LEN     = STEP_CYCLES
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // host control and detectors
  input wire logic       card_present,
  input wire logic       card_overcurrent,
  input wire logic       vcc_undervoltage,
  input wire logic       vdd_fault,
  input wire logic       host_reset_in,
  input wire logic       card_voltage_select,
  // card side
  input wire logic       vcc_enable,
  input wire logic [1:0] vcc_level,
  input wire logic       card_reset,
  input wire logic       card_clock,
  input wire logic       card_io_in,
  input wire logic       card_io_oe,
  // host side and status
  input wire logic       irq_n_out,
  input wire logic       irq_n_oe,
  input wire logic       host_io_in,
  input wire logic       host_io_oe,
  input wire logic       power_down,
  input wire logic       session_active
);
  // counters follow the pins only, so a design reset restarts nothing here
  int insert_cnt = 0;
  int tail_cnt = 0;

  always_ff @(posedge clk) begin
    insert_cnt <= card_present ? insert_cnt + 1 : 0;
    tail_cnt <= (session_active && !vcc_enable) ? tail_cnt + 1 : 0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  irq_pin_low_a: assert property (
    irq_n_out == 1'b0) else $error("interrupt pin drives high");
  debounce_len_a: assert property (
    $fell(irq_n_oe) |-> insert_cnt >= DEBOUNCE_LEN) else $error("presence seen too early");
  absent_irq_a: assert property (
    !card_present |-> ##3 irq_n_oe) else $error("no interrupt for absent card");
  start_needs_card_a: assert property (
    $rose(vcc_enable) |-> card_present && !irq_n_oe) else $error("supply on without card");
  supply_5v_a: assert property (
    $rose(vcc_enable) && card_voltage_select |-> vcc_level == VCC_5V0)
    else $error("wrong supply level");
  supply_session_a: assert property (
    vcc_enable |-> session_active) else $error("supply on outside session");
  clock_after_io_a: assert property (
    card_clock |-> vcc_enable && (!card_io_oe || !$past(host_io_in)))
    else $error("clock out of order");
  reset_copy_a: assert property (
    $rose(card_reset) |-> $past(host_reset_in)) else $error("card reset not from host");
  fault_reset_a: assert property (
    (card_overcurrent || vcc_undervoltage || vdd_fault) && session_active |-> ##2 !card_reset)
    else $error("fault did not drop card reset");
  deact_order_a: assert property (
    $fell(vcc_enable) |-> !card_reset && !card_clock && card_io_oe)
    else $error("supply removed before other lines");
  tail_len_a: assert property (
    tail_cnt <= STEP_LEN + 1) else $error("session end too late");
  relay_host_a: assert property (
    $fell(host_io_in) && card_io_in && !card_io_oe && !host_io_oe && vcc_enable |=> card_io_oe)
    else $error("host low not relayed");
  pdown_session_a: assert property (
    session_active && $past(session_active) |-> !power_down)
    else $error("power down in session");
endmodule : smcic_asserts

// file: smcic_card_model.sv
`timescale 1ns/1ps

module smcic_card_model (
  // clock and answer speed
  input wire logic clk,
  input wire logic slow,
  // contacts driven by the interface
  input wire logic card_reset,
  input wire logic card_io_oe,
  input wire logic card_aux4_oe,
  input wire logic card_aux8_oe,
  // contact levels, pulled up when nobody pulls low
  output logic     card_io_in,
  output logic     card_aux4_in,
  output logic     card_aux8_in
);
  logic       rst_seen = 1'b0;
  logic [4:0] wait_cnt = 5'h0;
  logic [2:0] low_cnt  = 3'h0;

  // answer to reset: after a short or long wait pull io low a few cycles
  always @(posedge clk) begin
    rst_seen <= card_reset;
    if (card_reset && !rst_seen) begin
      wait_cnt <= slow ? 5'h14 : 5'h2;
    end else if (wait_cnt != 5'h0) begin
      wait_cnt <= wait_cnt - 5'h1;
      if (wait_cnt == 5'h1) begin
        low_cnt <= 3'h6;
      end
    end
    if (low_cnt != 3'h0) begin
      low_cnt <= low_cnt - 3'h1;
    end
  end

  assign card_io_in   = !(card_io_oe || low_cnt != 3'h0);
  assign card_aux4_in = !card_aux4_oe;
  assign card_aux8_in = !card_aux8_oe;
endmodule : smcic_card_model

// file: smcic_clock_divide_select.sv
`timescale 1ns/1ps

module smcic_clock_divide_select
  import smcic_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // oscillator
  input  wire logic       osc_in,
  input  wire logic       stop_osc,
  output logic            osc_out,
  // control
  input  wire logic [1:0] div_code,
  input  wire logic       run,
  // card clock
  output logic            card_clk
);

  // ----------------------------------------------------------------------
  // ratio decode
  // ----------------------------------------------------------------------
  function automatic logic [3:0] edges_per_toggle(input logic [1:0] code);
    case (code)
      DIV_CODE_GND:  edges_per_toggle = EDGES_DIV4;
      DIV_CODE_TWO3: edges_per_toggle = EDGES_DIV8;
      DIV_CODE_FULL: edges_per_toggle = EDGES_DIV2;
      default:       edges_per_toggle = 4'h0;
    endcase
  endfunction : edges_per_toggle

  logic       osc_q_reg,    osc_q_next;
  logic [3:0] cnt_reg,      cnt_next;
  logic       card_clk_reg, card_clk_next;
  logic       osc_out_reg,  osc_out_next;
  logic [3:0] limit;

  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  always_comb begin
    limit         = edges_per_toggle(div_code);
    osc_q_next    = osc_in;
    cnt_next      = cnt_reg;
    card_clk_next = card_clk_reg;
    osc_out_next  = stop_osc ? 1'b0 : ~osc_in;
    if (!run) begin
      // stopping forces the card clock low at once, which may cut the last pulse short
      cnt_next      = 4'h0;
      card_clk_next = 1'b0;
    end else if (div_code == DIV_CODE_THIRD) begin
      card_clk_next = osc_in;
      cnt_next      = 4'h0;
    end else if (osc_in != osc_q_reg) begin
      // a count left above a smaller new limit ends at once, not after a wrap
      if (cnt_reg >= limit - 4'h1) begin
        cnt_next      = 4'h0;
        card_clk_next = ~card_clk_reg;
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_q_reg    <= 1'b0;
      cnt_reg      <= 4'h0;
      card_clk_reg <= 1'b0;
      osc_out_reg  <= 1'b0;
    end else begin
      osc_q_reg    <= osc_q_next;
      cnt_reg      <= cnt_next;
      card_clk_reg <= card_clk_next;
      osc_out_reg  <= osc_out_next;
    end
  end

  assign card_clk = card_clk_reg;
  assign osc_out  = osc_out_reg;

endmodule : smcic_clock_divide_select

// file: smcic_pkg.sv
package smcic_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_HZ        = 100_000_000;
  localparam int DEBOUNCE_MS        = 5;
  localparam int DEBOUNCE_CYCLES    = DEBOUNCE_MS * (CLK_FREQ_HZ / 1000);
  localparam int VSEL_WINDOW_NS     = 400;
  localparam int VSEL_WINDOW_CYCLES = (VSEL_WINDOW_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
  localparam int STEP_US            = 1;
  localparam int STEP_CYCLES        = STEP_US * (CLK_FREQ_HZ / 1_000_000);

  // ----------------------------------------------------------------------
  // quantised divide-select codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] DIV_CODE_GND   = 2'h0;
  localparam logic [1:0] DIV_CODE_THIRD = 2'h1;
  localparam logic [1:0] DIV_CODE_TWO3  = 2'h2;
  localparam logic [1:0] DIV_CODE_FULL  = 2'h3;

  // osc edges between card clock toggles, divide by n needs n edges
  localparam logic [3:0] EDGES_DIV2 = 4'h2;
  localparam logic [3:0] EDGES_DIV4 = 4'h4;
  localparam logic [3:0] EDGES_DIV8 = 4'h8;

  // ----------------------------------------------------------------------
  // card supply level codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] VCC_3V0 = 2'h0;
  localparam logic [1:0] VCC_5V0 = 2'h1;
  localparam logic [1:0] VCC_1V8 = 2'h2;
  localparam logic [1:0] VCC_RST = VCC_3V0;

  typedef enum {
    ST_IDLE, ST_VWAIT, ST_SUPPLY, ST_IO, ST_CLK, ST_ACTIVE,
    ST_D_RST, ST_D_CLK, ST_D_IO, ST_D_VCC
  } smcic_state_t;

endpackage : smcic_pkg

// file: smcic_tb.sv
`timescale 1ns/1ps

module smcic_tb;
  import smcic_pkg::*;
  localparam int DEBOUNCE_LEN = 20;
  localparam int STEP_LEN     = 4;
  logic       clk = 1'b0, rst_b = 1'b0, activate_cmd_n = 1'b1, host_reset_in = 1'b0;
  logic       card_voltage_select = 1'b1, card_present = 1'b0, osc_in = 1'b0, slow = 1'b0;
  logic       card_overcurrent = 1'b0, vcc_undervoltage = 1'b0, vdd_fault = 1'b0;
  logic [1:0] clock_divide_select = 2'h3, osc_cnt = 2'h0, vcc_level;
  logic [2:0] h_low = 3'h0;
  logic       osc_out, vcc_enable, card_reset, card_clock, irq_n_out, irq_n_oe;
  logic       power_down, session_active, host_io_in, host_aux4_in, host_aux8_in;
  logic       host_io_out, host_aux4_out, host_aux8_out, host_io_oe, host_aux4_oe, host_aux8_oe;
  logic       card_io_in, card_aux4_in, card_aux8_in, card_io_out, card_aux4_out, card_aux8_out;
  logic       card_io_oe, card_aux4_oe, card_aux8_oe;
  int         errors = 0, n_compared = 0, lat;
  wire [7:0]  mon = {session_active, vcc_enable, card_clock, card_reset,
                     irq_n_oe, power_down, host_io_oe, card_io_oe};
  wire [2:0]  c_oe = {card_aux8_oe, card_aux4_oe, card_io_oe};

  // host lines carry pull-ups, so released means high
  assign host_io_in   = !(host_io_oe || h_low[0]);
  assign host_aux4_in = !(host_aux4_oe || h_low[1]);
  assign host_aux8_in = !(host_aux8_oe || h_low[2]);

  always #5 clk = ~clk;
  // oscillator at one eighth of clk, far below the sampling limit
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 2'h1;
    if (osc_cnt == 2'h3) begin
      osc_in <= ~osc_in;
    end
  end

  smcic_top #(.DEBOUNCE_LEN(DEBOUNCE_LEN), .STEP_LEN(STEP_LEN)) smcic_top_i (
    .clk, .rst_b, .activate_cmd_n, .host_reset_in, .card_voltage_select, .clock_divide_select,
    .card_present, .card_overcurrent, .vcc_undervoltage, .vdd_fault, .osc_in, .osc_out,
    .vcc_enable, .vcc_level, .card_reset, .card_clock, .irq_n_out, .irq_n_oe,
    .host_io_in, .host_io_out, .host_io_oe, .host_aux4_in, .host_aux4_out, .host_aux4_oe,
    .host_aux8_in, .host_aux8_out, .host_aux8_oe, .card_io_in, .card_io_out, .card_io_oe,
    .card_aux4_in, .card_aux4_out, .card_aux4_oe, .card_aux8_in, .card_aux8_out,
    .card_aux8_oe, .power_down, .session_active);

  smcic_card_model smcic_card_model_i (.clk, .slow, .card_reset, .card_io_oe, .card_aux4_oe,
    .card_aux8_oe, .card_io_in, .card_aux4_in, .card_aux8_in);

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // waits for one monitor bit, cycles used left in lat
  task automatic wt(input int sel, input logic v, input int lim);
    lat = 0;
    while (mon[sel] !== v) begin
      if (lat == lim) begin
        errors++;
        $display("MISMATCH t=%0t wait on monitor bit %0d timed out", $time, sel);
        final_report();
      end
      @(posedge clk);
      lat++;
    end
  endtask : wt

  task automatic t_refuse;
    activate_cmd_n <= 1'b0;
    cyc(60);
    chk(mon[7:6], 8'h0, "start without card");
    activate_cmd_n <= 1'b1;
    cyc(2);
    $display("refuse test done");
  endtask : t_refuse

  task automatic t_present;
    card_present <= 1'b1;
    cyc(DEBOUNCE_LEN - 5);
    card_present <= 1'b0;
    cyc(8);
    chk(irq_n_oe, 8'h1, "short insertion");
    host_reset_in <= 1'b1;
    cyc(3);
    chk({power_down, osc_out}, 8'h2, "idle power down, oscillator stopped");
    host_reset_in <= 1'b0;
    card_present  <= 1'b1;
    cyc(DEBOUNCE_LEN + 3);
    chk({power_down, irq_n_oe}, 8'h0, "card present");
    $display("presence test done");
  endtask : t_present

  task automatic t_act(input logic vs, input logic late, input logic [1:0] lvl);
    card_voltage_select <= vs; // settled before activation, held unless late drops it after activation
    // a fall just before activation must still count as an early 1.8V pick
    cyc(vs ? 50 : 10);
    activate_cmd_n <= 1'b0;
    if (late) begin
      cyc(5);
      card_voltage_select <= 1'b0;
    end
    wt(6, 1'b1, 90);
    chk(vcc_level, lvl, "supply level");
    chk(card_io_oe, 8'h1, "io held at supply on");
    wt(0, 1'b0, 3 * STEP_LEN + 4);
    wt(5, 1'b1, 3 * STEP_LEN + 40);
    host_reset_in <= 1'b1;
    wt(4, 1'b1, 2 * STEP_LEN + 4);
    chk(power_down, 8'h0, "no power down in session");
    $display("activation test done");
  endtask : t_act

  task automatic t_div;
    int exp_per [4];
    int p;
    exp_per = '{32, 8, 64, 16};
    for (int c = 0; c < 4; c++) begin
      clock_divide_select <= c[1:0];
      repeat (2) begin
        wt(5, 1'b0, 80);
        wt(5, 1'b1, 80);
      end
      wt(5, 1'b0, 80);
      p = lat;
      wt(5, 1'b1, 80);
      p += lat;
      chk(p[7:0], exp_per[c][7:0], "card clock period");
    end
    $display("divider test done");
  endtask : t_div

  task automatic t_relay;
    for (int i = 0; i < 3; i++) begin
      h_low[i] <= 1'b1;
      cyc(3);
      chk(c_oe, 8'h1 << i, "host low to card");
      chk({host_aux8_oe, host_aux4_oe, host_io_oe}, 8'h0, "no echo to host");
      h_low[i] <= 1'b0;
      cyc(3);
      chk(c_oe, 8'h0, "host release to card");
    end
    for (int s = 0; s < 2; s++) begin
      slow          <= s[0];
      host_reset_in <= 1'b0;
      cyc(3);
      host_reset_in <= 1'b1;
      wt(1, 1'b1, 60);
      wt(1, 1'b0, 20);
    end
    chk({irq_n_out, host_io_out, host_aux4_out, host_aux8_out, card_io_out, card_aux4_out,
         card_aux8_out}, 8'h0, "open drain levels low");
    $display("relay test done");
  endtask : t_relay

  task automatic t_stop;
    activate_cmd_n <= 1'b1;
    wt(7, 1'b0, 4 * STEP_LEN + 8);
    chk({irq_n_oe, card_io_oe, vcc_enable}, 8'h2, "normal end");
    host_reset_in <= 1'b0;
    $display("release test done");
  endtask : t_stop

  task automatic t_deact(input int f);
    t_act(1'b0, 1'b0, VCC_3V0);
    case (f)
      0: card_overcurrent <= 1'b1;
      1: vcc_undervoltage <= 1'b1;
      2: vdd_fault <= 1'b1;
      default: card_present <= 1'b0;
    endcase
    wt(4, 1'b0, 3);
    wt(6, 1'b0, 3 * STEP_LEN + 6);
    wt(7, 1'b0, STEP_LEN + 3);
    chk({irq_n_oe, card_io_oe, card_clock}, 8'h6, "after emergency stop");
    {vdd_fault, vcc_undervoltage, card_overcurrent} <= 3'h0;
    activate_cmd_n <= 1'b1;
    card_present   <= 1'b1;
    host_reset_in  <= 1'b0;
    wt(3, 1'b0, DEBOUNCE_LEN + 10);
    $display("emergency test %0d done", f);
  endtask : t_deact

  initial begin
    cyc(8);
    chk({vcc_enable, card_io_oe, host_io_oe, irq_n_oe}, 8'h5, "reset state");
    rst_b <= 1'b1;
    t_refuse();
    t_present();
    t_act(1'b1, 1'b0, VCC_5V0);
    t_div();
    t_relay();
    t_stop();
    t_act(1'b0, 1'b0, VCC_1V8);
    t_stop();
    t_act(1'b1, 1'b1, VCC_1V8);
    t_stop();
    for (int f = 0; f < 4; f++) begin
      t_deact(f);
    end
    final_report();
  end
endmodule : smcic_tb

bind smcic_top smcic_asserts #(.DEBOUNCE_LEN(DEBOUNCE_LEN), .STEP_LEN(STEP_LEN)) smcic_asserts_i (
  .clk, .rst_b, .card_present, .card_overcurrent, .vcc_undervoltage, .vdd_fault,
  .host_reset_in, .card_voltage_select, .vcc_enable, .vcc_level, .card_reset, .card_clock,
  .card_io_in, .card_io_oe, .irq_n_out, .irq_n_oe, .host_io_in, .host_io_oe, .power_down,
  .session_active);

// file: smcic_top.sv
// Functional notes
// - high presence means inserted, 5 ms insertion debounce
// - activation falling edge starts session if present
// - voltage select high 5V, low 3V
// - select falling near activation edge picks 1.8V
// - card clock is oscillator divided by 1,2,4,8
// - open-drain low interrupt flags fault and card absence
// - in the active state host reset drives card reset
// - in the idle state host reset means power-down
// - removal or any fault starts emergency deactivation
// - sequencer switches card supply on and off
// - data, aux4, aux8 relayed both ways from ST_IO through ST_D_CLK
`timescale 1ns/1ps

module smcic_top
  import smcic_pkg::*;
#(
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
  parameter int STEP_LEN     = STEP_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // host control
  input  wire logic       activate_cmd_n,
  input  wire logic       host_reset_in,
  input  wire logic       card_voltage_select,
  input  wire logic [1:0] clock_divide_select,
  input  wire logic       card_present,
  // fault detectors
  input  wire logic       card_overcurrent,
  input  wire logic       vcc_undervoltage,
  input  wire logic       vdd_fault,
  // oscillator
  input  wire logic       osc_in,
  output logic            osc_out,
  // card supply, reset and clock
  output logic            vcc_enable,
  output logic [1:0]      vcc_level,
  output logic            card_reset,
  output logic            card_clock,
  // interrupt, open drain
  output logic            irq_n_out,
  output logic            irq_n_oe,
  // host side data lines
  input  wire logic       host_io_in,
  output logic            host_io_out,
  output logic            host_io_oe,
  input  wire logic       host_aux4_in,
  output logic            host_aux4_out,
  output logic            host_aux4_oe,
  input  wire logic       host_aux8_in,
  output logic            host_aux8_out,
  output logic            host_aux8_oe,
  // card side data lines
  input  wire logic       card_io_in,
  output logic            card_io_out,
  output logic            card_io_oe,
  input  wire logic       card_aux4_in,
  output logic            card_aux4_out,
  output logic            card_aux4_oe,
  input  wire logic       card_aux8_in,
  output logic            card_aux8_out,
  output logic            card_aux8_oe,
  // status
  output logic            power_down,
  output logic            session_active
);

  localparam int DEB_W = $clog2(DEBOUNCE_LEN + 1);
  localparam int TMR_W = 16;
  localparam logic [5:0] WIN = 6'(VSEL_WINDOW_CYCLES);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  smcic_state_t     state_reg,    state_next;
  logic [TMR_W-1:0] timer_reg,    timer_next;
  logic [DEB_W-1:0] deb_cnt_reg,  deb_cnt_next;
  logic             present_reg,  present_next;
  logic             vsel_q_reg,   vsel_q_next;
  logic             cmd_q_reg,    cmd_q_next;
  logic [5:0]       since_reg,    since_next;
  logic [1:0]       level_reg,    level_next;
  logic             fault_reg,    fault_next;
  logic             vcc_en_reg,   vcc_en_next;
  logic             rst_reg,      rst_next;
  logic             pd_reg,       pd_next;
  logic             sess_reg,     sess_next;
  logic             irq_oe_reg,   irq_oe_next;
  logic [2:0]       card_oe_reg,  card_oe_next;
  logic [2:0]       host_oe_reg,  host_oe_next;
  logic             zero_reg;
  logic             clk_run;
  logic             io_rel;
  logic             vsel_fall;
  logic             cmd_fall;
  logic             fault_in;
  logic             abort;
  logic             step_done;
  logic [2:0]       host_lvl;
  logic [2:0]       card_lvl;

  assign host_lvl  = {host_aux8_in, host_aux4_in, host_io_in};
  assign card_lvl  = {card_aux8_in, card_aux4_in, card_io_in};
  assign vsel_fall = vsel_q_reg & ~card_voltage_select;
  assign cmd_fall  = cmd_q_reg & ~activate_cmd_n;
  assign fault_in  = card_overcurrent | vcc_undervoltage | vdd_fault;
  assign step_done = (timer_reg == TMR_W'(STEP_LEN - 1));
  assign clk_run   = (state_reg == ST_CLK) || (state_reg == ST_ACTIVE) ||
                     (state_reg == ST_D_RST);
  assign io_rel    = clk_run || (state_reg == ST_IO) || (state_reg == ST_D_CLK);

  // ----------------------------------------------------------------------
  // presence, edges and sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    deb_cnt_next = deb_cnt_reg;
    present_next = present_reg;
    if (!card_present) begin
      // extraction is acted on at once, only insertion is filtered
      deb_cnt_next = '0;
      present_next = 1'b0;
    end else if (deb_cnt_reg == DEB_W'(DEBOUNCE_LEN - 1)) begin
      present_next = 1'b1;
    end else begin
      deb_cnt_next = deb_cnt_reg + 1'b1;
    end

    vsel_q_next = card_voltage_select;
    cmd_q_next  = activate_cmd_n;
    since_next  = vsel_fall ? 6'h0 : ((since_reg > WIN) ? since_reg : since_reg + 6'h1);

    abort      = ~present_reg | fault_in;
    state_next = state_reg;
    timer_next = step_done ? '0 : timer_reg + 1'b1;
    level_next = level_reg;
    case (state_reg)
      ST_IDLE: begin
        timer_next = '0;
        if (cmd_fall && present_reg && !fault_in) begin
          state_next = ST_VWAIT;
          if (since_reg <= WIN) begin
            level_next = VCC_1V8;
          end else begin
            level_next = card_voltage_select ? VCC_5V0 : VCC_3V0;
          end
        end
      end
      ST_VWAIT: begin
        // holding the supply off until the late window closes avoids
        // ramping to the wrong level for a 1.8V card
        // the window may outlast one step, so the step wrap is not used here
        timer_next = timer_reg + 1'b1;
        if (vsel_fall) begin
          level_next = VCC_1V8;
        end
        if (abort || activate_cmd_n) begin
          state_next = ST_IDLE;
        end else if (timer_reg == TMR_W'(WIN)) begin
          state_next = ST_SUPPLY;
          timer_next = '0;
        end
      end
      ST_SUPPLY, ST_IO, ST_CLK: begin
        if (abort || activate_cmd_n) begin
          state_next = ST_D_RST;
          timer_next = '0;
        end else if (step_done) begin
          case (state_reg)
            ST_SUPPLY: state_next = ST_IO;
            ST_IO:     state_next = ST_CLK;
            default:   state_next = ST_ACTIVE;
          endcase
        end
      end
      ST_ACTIVE: begin
        timer_next = '0;
        if (abort || activate_cmd_n) begin
          state_next = ST_D_RST;
        end
      end
      ST_D_RST: if (step_done) state_next = ST_D_CLK;
      ST_D_CLK: if (step_done) state_next = ST_D_IO;
      ST_D_IO:  if (step_done) state_next = ST_D_VCC;
      ST_D_VCC: if (step_done) state_next = ST_IDLE;
      default: begin
        state_next = ST_IDLE;
      end
    endcase

    vcc_en_next = (state_next inside {ST_SUPPLY, ST_IO, ST_CLK, ST_ACTIVE,
                                      ST_D_RST, ST_D_CLK, ST_D_IO});
    rst_next    = (state_next == ST_ACTIVE) & host_reset_in;
    pd_next     = (state_next == ST_IDLE) & host_reset_in;
    sess_next   = (state_next != ST_IDLE) && (state_next != ST_VWAIT);

    // set wins over the clear by the host releasing activation
    fault_next  = fault_in | ((state_reg != ST_IDLE) & ~present_reg) |
                  (fault_reg & ~activate_cmd_n);
    irq_oe_next = fault_next | ~present_next;
  end

  // ----------------------------------------------------------------------
  // data line relay
  // ----------------------------------------------------------------------
  always_comb begin
    card_oe_next = card_oe_reg;
    host_oe_next = host_oe_reg;
    for (int i = 0; i < 3; i++) begin
      if (!io_rel) begin
        card_oe_next[i] = 1'b1;
        host_oe_next[i] = 1'b0;
      end else if (card_oe_reg[i]) begin
        card_oe_next[i] = ~host_lvl[i];
      end else if (host_oe_reg[i]) begin
        host_oe_next[i] = ~card_lvl[i];
      end else if (!host_lvl[i] && card_lvl[i]) begin
        card_oe_next[i] = 1'b1;
      end else if (!card_lvl[i] && host_lvl[i]) begin
        host_oe_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg   <= ST_IDLE;
      timer_reg   <= '0;
      deb_cnt_reg <= '0;
      present_reg <= 1'b0;
      vsel_q_reg  <= 1'b1;
      cmd_q_reg   <= 1'b1;
      since_reg   <= 6'h3f;
      level_reg   <= VCC_RST;
      fault_reg   <= 1'b0;
      vcc_en_reg  <= 1'b0;
      rst_reg     <= 1'b0;
      pd_reg      <= 1'b0;
      sess_reg    <= 1'b0;
      irq_oe_reg  <= 1'b1;
      card_oe_reg <= 3'h7;
      host_oe_reg <= 3'h0;
      zero_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      timer_reg   <= timer_next;
      deb_cnt_reg <= deb_cnt_next;
      present_reg <= present_next;
      vsel_q_reg  <= vsel_q_next;
      cmd_q_reg   <= cmd_q_next;
      since_reg   <= since_next;
      level_reg   <= level_next;
      fault_reg   <= fault_next;
      vcc_en_reg  <= vcc_en_next;
      rst_reg     <= rst_next;
      pd_reg      <= pd_next;
      sess_reg    <= sess_next;
      irq_oe_reg  <= irq_oe_next;
      card_oe_reg <= card_oe_next;
      host_oe_reg <= host_oe_next;
      zero_reg    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // card clock
  // ----------------------------------------------------------------------
  // a divide change while the clock runs may give one short pulse
  smcic_clock_divide_select u_clock_divide_select (
    .clk      (clk),
    .rst_b    (rst_b),
    .osc_in   (osc_in),
    .stop_osc (pd_reg),
    .osc_out  (osc_out),
    .div_code (clock_divide_select),
    .run      (clk_run),
    .card_clk (card_clock)
  );

  assign vcc_enable     = vcc_en_reg;
  assign vcc_level      = level_reg;
  assign card_reset     = rst_reg;
  assign irq_n_out      = zero_reg;
  assign irq_n_oe       = irq_oe_reg;
  assign power_down     = pd_reg;
  assign session_active = sess_reg;
  assign host_io_out    = zero_reg;
  assign host_aux4_out  = zero_reg;
  assign host_aux8_out  = zero_reg;
  assign card_io_out    = zero_reg;
  assign card_aux4_out  = zero_reg;
  assign card_aux8_out  = zero_reg;
  assign host_io_oe     = host_oe_reg[0];
  assign host_aux4_oe   = host_oe_reg[1];
  assign host_aux8_oe   = host_oe_reg[2];
  assign card_io_oe     = card_oe_reg[0];
  assign card_aux4_oe   = card_oe_reg[1];
  assign card_aux8_oe   = card_oe_reg[2];

endmodule : smcic_top
